// >>> core/psp_pkg.sv
package psp_pkg;

  // clock and time base
  localparam int CLK_HZ = 20000000;
  localparam int TICK_PERIOD_MS = 1;
  localparam int MS_TICK_CYCLES = (CLK_HZ / 1000) * TICK_PERIOD_MS;
  localparam int TICK_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // rearm pulse limits, in milliseconds
  localparam int HIGH_W = 15;
  localparam logic [HIGH_W-1:0] MIN_SHORT_MS = 15'd100;
  localparam logic [HIGH_W-1:0] MIN_LONG_MS = 15'd350;
  localparam logic [HIGH_W-1:0] MAX_HIGH_MS = 15'd30000;
  localparam logic [HIGH_W-1:0] SAT_HIGH_MS = 15'd30001;

  ////////////////////////////////////////////////////////////////////////////
  // lockout mode encodings
  localparam int MODE_W = 3;
  localparam logic [MODE_W-1:0] LOCK_NONE = 3'h1;
  localparam logic [MODE_W-1:0] LOCK_ALWAYS = 3'h2;
  localparam logic [MODE_W-1:0] LOCK_STARTSTOP = 3'h3;
  localparam logic [MODE_W-1:0] LOCK_TDC = 3'h4;

  // reset values
  localparam logic LOCK_RESET = 1'b1;
  localparam logic PERMIT_RESET = 1'b0;

endpackage

// >>> core/psp_ms_tick.sv
`timescale 1ns/100ps

module psp_ms_tick #(
  parameter int TICK_CYCLES = psp_pkg::MS_TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  output logic msTick
);

  logic [psp_pkg::TICK_W-1:0] cnt_q;

  // one pulse per millisecond, free running
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      msTick <= 1'b0;
    end else if (cnt_q == psp_pkg::TICK_W'(TICK_CYCLES - 1)) begin
      cnt_q <= '0;
      msTick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      msTick <= 1'b0;
    end
  end

  property p_tickSpaced;
    @(posedge clk_sys) disable iff (rst)
    msTick && (TICK_CYCLES > 1) |=> !msTick;
  endproperty
  a_tickSpaced: assert property (p_tickSpaced) else $error("ms tick wider than one cycle");

endmodule

// >>> core/psp_rearm_check.sv
`timescale 1ns/100ps

module psp_rearm_check (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic msTick,
  input wire logic rearmReq,
  input wire logic minPulseLong,
  output logic pulseOk
);

  logic reqPrev_q;
  logic [psp_pkg::HIGH_W-1:0] highMs_q;
  logic [psp_pkg::HIGH_W-1:0] minMs;
  logic reqRise;
  logic reqFall;

  assign minMs = minPulseLong ? psp_pkg::MIN_LONG_MS : psp_pkg::MIN_SHORT_MS;
  assign reqRise = rearmReq && !reqPrev_q;
  assign reqFall = !rearmReq && reqPrev_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reqPrev_q <= 1'b0;
    end else begin
      reqPrev_q <= rearmReq;
    end
  end

  // saturates just past the limit so overlong pulses stay overlong
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      highMs_q <= '0;
    end else if (reqRise) begin
      highMs_q <= '0;
    end else if (rearmReq && msTick && highMs_q != psp_pkg::SAT_HIGH_MS) begin
      highMs_q <= highMs_q + 1'b1;
    end
  end

  // low-high-low only, high phase inside the window
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pulseOk <= 1'b0;
    end else begin
      pulseOk <= reqFall && highMs_q >= minMs && highMs_q <= psp_pkg::MAX_HIGH_MS;
    end
  end

  property p_okInRange;
    @(posedge clk_sys) disable iff (rst)
    pulseOk |-> $past(highMs_q) >= $past(minMs) && $past(highMs_q) <= psp_pkg::MAX_HIGH_MS;
  endproperty
  a_okInRange: assert property (p_okInRange) else $error("rearm accepted outside window");

  property p_longIgnored;
    @(posedge clk_sys) disable iff (rst)
    reqFall && highMs_q > psp_pkg::MAX_HIGH_MS |=> !pulseOk;
  endproperty
  a_longIgnored: assert property (p_longIgnored) else $error("overlong rearm accepted");

  property p_okOnFall;
    @(posedge clk_sys) disable iff (rst)
    pulseOk |-> $past(reqPrev_q) && !$past(rearmReq);
  endproperty
  a_okOnFall: assert property (p_okOnFall) else $error("rearm accepted without falling edge");

  property p_saturate;
    @(posedge clk_sys) disable iff (rst)
    highMs_q <= psp_pkg::SAT_HIGH_MS;
  endproperty
  a_saturate: assert property (p_saturate) else $error("pulse counter past saturation");

endmodule

// >>> core/psp_press_permit.sv
`timescale 1ns/100ps

// Functional notes
// - permit rises only on start rise, no pending rearm, main and configured start permits high
// - without single-cycle checking, start fall or low main permit drops permit
// - with single-cycle checking, a top-dead-center rise also drops permit
// - rearm-pending is high while a valid rearm pulse is awaited
// - only a valid rearm pulse sequence clears the lockout
// - permit held low while rearm-pending is high
// - valid rearm pulse is low-high-low on the rearm request
// - high phase lasts at least 100 ms or 350 ms as selected
// - pulses too short or over 30 s are ignored, flag unchanged
// - inverted main permit output is complement of main permit
// - lockout mode 1 none, 2 every stop, 3 start/main drop, 4 tdc/main drop
// - rearm-pending shown only when main permit and configured start permit high
// - start permit not evaluated once the permit is high
module psp_press_permit #(
  parameter int TICK_CYCLES = psp_pkg::MS_TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic startStop,
  input wire logic mainPermit,
  input wire logic startPermit,
  input wire logic startPermitEn,
  input wire logic tdc,
  input wire logic singleCycleEn,
  input wire logic [psp_pkg::MODE_W-1:0] lockMode,
  input wire logic minPulseLong,
  input wire logic rearmReq,
  output logic pressPermit,
  output logic rearmPending,
  output logic mainPermitInv
);

  ////////////////////////////////////////////////////////////////////////////
  // sampled inputs and edges

  logic ssPrev_q;
  logic mainPrev_q;
  logic tdcPrev_q;
  logic ssRise;
  logic ssFall;
  logic mainFall;
  logic tdcRise;
  logic msTick;
  logic rearmOk;
  logic lock_q;
  logic lock_d;
  logic lockActive;
  logic preOk;
  logic stopEvent;
  logic lockEvent;
  logic pressPermit_d;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ssPrev_q <= 1'b0;
      mainPrev_q <= 1'b0;
      tdcPrev_q <= 1'b0;
    end else begin
      ssPrev_q <= startStop;
      mainPrev_q <= mainPermit;
      tdcPrev_q <= tdc;
    end
  end

  assign ssRise = startStop && !ssPrev_q;
  assign ssFall = !startStop && ssPrev_q;
  assign mainFall = !mainPermit && mainPrev_q;
  // tdc only counts when single-cycle checking is on
  assign tdcRise = singleCycleEn && tdc && !tdcPrev_q;

  ////////////////////////////////////////////////////////////////////////////
  // time base and rearm pulse qualification

  psp_ms_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_sys(clk_sys),
    .rst(rst),
    .msTick(msTick)
  );

  psp_rearm_check u_rearm (
    .clk_sys(clk_sys),
    .rst(rst),
    .msTick(msTick),
    .rearmReq(rearmReq),
    .minPulseLong(minPulseLong),
    .pulseOk(rearmOk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // lockout

  // start permit matters only while it is configured
  assign preOk = mainPermit && (startPermit || !startPermitEn);
  assign lockActive = lock_q && lockMode != psp_pkg::LOCK_NONE;
  assign stopEvent = ssFall || mainFall || tdcRise;

  // which stops arm the lockout; a drop only counts while the press runs
  always_comb begin
    lockEvent = 1'b0;
    case (lockMode)
      psp_pkg::LOCK_ALWAYS: lockEvent = stopEvent;
      psp_pkg::LOCK_STARTSTOP: lockEvent = ssFall || mainFall;
      psp_pkg::LOCK_TDC: lockEvent = tdcRise || mainFall;
      default: lockEvent = 1'b0;
    endcase
  end

  // set wins over clear; a rejected pulse leaves the flag alone
  always_comb begin
    lock_d = lock_q;
    if (rearmOk && rearmPending) begin
      lock_d = 1'b0;
    end
    if (lockEvent && pressPermit) begin
      lock_d = 1'b1;
    end
  end

  // mode is a port, so the lock starts armed and mode 1 masks it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lock_q <= psp_pkg::LOCK_RESET;
    end else begin
      lock_q <= lock_d;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rearmPending <= 1'b0;
    end else begin
      rearmPending <= lockActive && preOk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // press permit

  always_comb begin
    pressPermit_d = pressPermit;
    if (lockActive) begin
      pressPermit_d = 1'b0;
    end else if (!pressPermit) begin
      pressPermit_d = ssRise && preOk;
    end else if (ssFall || !mainPermit || tdcRise) begin
      pressPermit_d = 1'b0;
    end
    // running: start permit no longer looked at
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pressPermit <= psp_pkg::PERMIT_RESET;
    end else begin
      pressPermit <= pressPermit_d;
    end
  end

  // combinational so the complement never lags the input
  assign mainPermitInv = !mainPermit;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_startRequest;
    ssRise && !lockActive && preOk;
  endsequence

  sequence s_running;
    pressPermit && !lockActive;
  endsequence

  property p_riseCause;
    @(posedge clk_sys) disable iff (rst)
    $rose(pressPermit) |-> $past(ssRise) && !$past(lockActive) && $past(preOk);
  endproperty
  a_riseCause: assert property (p_riseCause) else $error("permit rose without valid start");

  property p_riseTaken;
    @(posedge clk_sys) disable iff (rst)
    !pressPermit ##0 s_startRequest |=> pressPermit;
  endproperty
  a_riseTaken: assert property (p_riseTaken) else $error("valid start not taken");

  property p_dropStop;
    @(posedge clk_sys) disable iff (rst)
    pressPermit && ssFall |=> !pressPermit;
  endproperty
  a_dropStop: assert property (p_dropStop) else $error("permit kept after start fall");

  property p_dropMain;
    @(posedge clk_sys) disable iff (rst)
    !mainPermit |=> !pressPermit;
  endproperty
  a_dropMain: assert property (p_dropMain) else $error("permit high with main permit low");

  property p_dropTdc;
    @(posedge clk_sys) disable iff (rst)
    singleCycleEn && tdc && !tdcPrev_q |=> !pressPermit;
  endproperty
  a_dropTdc: assert property (p_dropTdc) else $error("permit kept after tdc rise");

  property p_pendingShow;
    @(posedge clk_sys) disable iff (rst)
    lock_q && lockMode != psp_pkg::LOCK_NONE && preOk |=> rearmPending;
  endproperty
  a_pendingShow: assert property (p_pendingShow) else $error("rearm pending not shown");

  property p_lockClear;
    @(posedge clk_sys) disable iff (rst)
    $fell(lock_q) |-> $past(rearmOk) && $past(rearmPending);
  endproperty
  a_lockClear: assert property (p_lockClear) else $error("lock cleared without valid rearm");

  property p_lockHold;
    @(posedge clk_sys) disable iff (rst)
    rearmPending |-> !pressPermit;
  endproperty
  a_lockHold: assert property (p_lockHold) else $error("permit high while rearm pending");

  property p_invert;
    @(posedge clk_sys) disable iff (rst)
    mainPermitInv != mainPermit;
  endproperty
  a_invert: assert property (p_invert) else $error("inverted main permit wrong");

  property p_lockArm;
    @(posedge clk_sys) disable iff (rst)
    lockMode == psp_pkg::LOCK_ALWAYS && pressPermit && ssFall |=> lock_q [*2];
  endproperty
  a_lockArm: assert property (p_lockArm) else $error("stop did not arm lockout");

  property p_noLockMode1;
    @(posedge clk_sys) disable iff (rst)
    lockMode == psp_pkg::LOCK_NONE && $past(lockMode) == psp_pkg::LOCK_NONE |-> !rearmPending;
  endproperty
  a_noLockMode1: assert property (p_noLockMode1) else $error("rearm pending in mode 1");

  property p_pendingPre;
    @(posedge clk_sys) disable iff (rst)
    rearmPending |-> $past(mainPermit) && ($past(startPermit) || !$past(startPermitEn));
  endproperty
  a_pendingPre: assert property (p_pendingPre) else $error("rearm pending without preconditions");

  property p_holdRun;
    @(posedge clk_sys) disable iff (rst)
    s_running ##0 (mainPermit && !ssFall && !tdcRise) |=> pressPermit;
  endproperty
  a_holdRun: assert property (p_holdRun) else $error("permit dropped without stop cause");

  property p_edgeSample;
    @(posedge clk_sys) disable iff (rst)
    ssRise |=> ssPrev_q;
  endproperty
  a_edgeSample: assert property (p_edgeSample) else $error("start sample not updated");

  // pending high implies permit low, so no set can race the clear here
  sequence s_unlocked;
    !lock_q ##1 !rearmPending;
  endsequence

  property p_rearmClears;
    @(posedge clk_sys) disable iff (rst)
    rearmOk && rearmPending |=> s_unlocked;
  endproperty
  a_rearmClears: assert property (p_rearmClears) else $error("valid rearm did not clear lockout");

  property p_lockStays;
    @(posedge clk_sys) disable iff (rst)
    lock_q && !rearmOk |=> lock_q;
  endproperty
  a_lockStays: assert property (p_lockStays) else $error("lockout cleared without accepted pulse");

  property p_stopLocks3;
    @(posedge clk_sys) disable iff (rst)
    lockMode == psp_pkg::LOCK_STARTSTOP && pressPermit && (ssFall || mainFall) |=> lock_q;
  endproperty
  a_stopLocks3: assert property (p_stopLocks3) else $error("start or main drop did not lock");

  property p_tdcLocks4;
    @(posedge clk_sys) disable iff (rst)
    lockMode == psp_pkg::LOCK_TDC && pressPermit && tdcRise |=> lock_q;
  endproperty
  a_tdcLocks4: assert property (p_tdcLocks4) else $error("tdc rise did not lock");

  property p_stopFree4;
    @(posedge clk_sys) disable iff (rst)
    lockMode == psp_pkg::LOCK_TDC && !lock_q && ssFall && !mainFall && !tdcRise |=> !lock_q;
  endproperty
  a_stopFree4: assert property (p_stopFree4) else $error("plain stop locked in tdc mode");

  property p_modeNoneFree;
    @(posedge clk_sys) disable iff (rst)
    lockMode == psp_pkg::LOCK_NONE && !pressPermit && ssRise && preOk |=> pressPermit;
  endproperty
  a_modeNoneFree: assert property (p_modeNoneFree) else $error("start refused without lockout");

  property p_tdcIgnored;
    @(posedge clk_sys) disable iff (rst)
    !singleCycleEn && pressPermit && !lockActive && mainPermit && !ssFall |=> pressPermit;
  endproperty
  a_tdcIgnored: assert property (p_tdcIgnored) else $error("permit dropped with checking off");

endmodule

// >>> dv/psp_operator.sv
`timescale 1ns/100ps

// operator side: rearm button held for a set number of clock cycles
module psp_operator (
  input wire logic clk_sys,
  output logic rearmReq
);
  initial rearmReq = 1'b0;

  // edges land on the falling clock so the device never samples mid-change
  task automatic pulse(input int hiCycles);
    @(negedge clk_sys);
    rearmReq = 1'b1;
    repeat (hiCycles) @(negedge clk_sys);
    rearmReq = 1'b0;
    // device needs a few cycles after the fall before the lock clears
    repeat (8) @(negedge clk_sys);
  endtask
endmodule

// >>> dv/psp_press_permit_tb_top.sv
`timescale 1ns/100ps

module psp_press_permit_tb_top;
  // short tick keeps the 30 s case near 60000 cycles
  localparam int TICK = 2;
  logic clk_sys, rst, startStop, mainPermit, startPermit, startPermitEn, tdc, singleCycleEn, minPulseLong;
  logic [psp_pkg::MODE_W-1:0] lockMode;
  logic rearmReq, pressPermit, rearmPending, mainPermitInv;
  logic [31:0] lfsrQ;
  logic expPermit, expPend;
  int mismatches, checks;
  // reference model state, advanced once per clock from the rules
  int mHighCyc, mMs, mMinMs;
  int pulseQ[$];
  logic mSs, mMain, mTdc, mReq, mLock, mPermit, mPend;
  logic mPre, mSsRise, mSsFall, mMainFall, mTdcRise, mLockOn, mEvent, mOk, mNext;

  psp_press_permit #(.TICK_CYCLES(TICK)) i_dut (.clk_sys(clk_sys), .rst(rst), .startStop(startStop),
    .mainPermit(mainPermit), .startPermit(startPermit), .startPermitEn(startPermitEn), .tdc(tdc),
    .singleCycleEn(singleCycleEn), .lockMode(lockMode), .minPulseLong(minPulseLong), .rearmReq(rearmReq),
    .pressPermit(pressPermit), .rearmPending(rearmPending), .mainPermitInv(mainPermitInv));
  psp_operator i_op (.clk_sys(clk_sys), .rearmReq(rearmReq));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // outputs are registered, three cycles covers edge detect plus flop
  task automatic settle(input string what);
    step(3);
    check({what, " permit"}, pressPermit, expPermit);
    check({what, " pending"}, rearmPending, expPend);
    check({what, " model permit"}, pressPermit, mPermit);
    check({what, " model pending"}, rearmPending, mPend);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // widths kept in ms on a queue and judged one clock after the fall
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {mSs, mMain, mTdc, mReq, mPermit, mPend} <= 6'h00;
      mLock <= psp_pkg::LOCK_RESET;
      mHighCyc <= 0;
      pulseQ.delete();
    end else begin
      mPre = mainPermit && (startPermit || !startPermitEn);
      mSsRise = startStop && !mSs;
      mSsFall = !startStop && mSs;
      mMainFall = !mainPermit && mMain;
      mTdcRise = singleCycleEn && tdc && !mTdc;
      mLockOn = mLock && lockMode != psp_pkg::LOCK_NONE;
      case (lockMode)
        psp_pkg::LOCK_ALWAYS: mEvent = mSsFall || mMainFall || mTdcRise;
        psp_pkg::LOCK_STARTSTOP: mEvent = mSsFall || mMainFall;
        psp_pkg::LOCK_TDC: mEvent = mTdcRise || mMainFall;
        default: mEvent = 1'b0;
      endcase
      mOk = 1'b0;
      if (pulseQ.size() > 0) begin
        mMs = pulseQ.pop_front();
        mMinMs = minPulseLong ? int'(psp_pkg::MIN_LONG_MS) : int'(psp_pkg::MIN_SHORT_MS);
        mOk = mMs >= mMinMs && mMs <= int'(psp_pkg::MAX_HIGH_MS);
      end
      if (rearmReq) begin
        mHighCyc <= mReq ? mHighCyc + 1 : 1;
      end else if (mReq) begin
        pulseQ.push_back(mHighCyc / TICK);
      end
      if (mLockOn) begin
        mNext = 1'b0;
      end else if (!mPermit) begin
        mNext = mSsRise && mPre;
      end else if (mSsFall || !mainPermit || mTdcRise) begin
        mNext = 1'b0;
      end else begin
        mNext = mPermit;
      end
      // a stop while running outweighs a same-cycle rearm
      if (mEvent && mPermit) begin
        mLock <= 1'b1;
      end else if (mOk && mPend) begin
        mLock <= 1'b0;
      end
      mPend <= mLockOn && mPre;
      mPermit <= mNext;
      {mSs, mMain, mTdc, mReq} <= {startStop, mainPermit, tdc, rearmReq};
    end
  end

  // no wait may hang the run
  initial begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    lfsrQ = 32'h2de3;
    {startStop, startPermit, startPermitEn, tdc, singleCycleEn, minPulseLong} = 6'h00;
    lockMode = psp_pkg::LOCK_ALWAYS;
    mainPermit = 1'b1;
    rst = 1'b1;
    expPermit = 1'b0;
    expPend = 1'b1;
    step(6);
    rst = 1'b0;
    settle("boot");
    startStop = 1'b1;
    settle("start while locked");
    startStop = 1'b0;
    i_op.pulse(90 * TICK);
    settle("short pulse");
    minPulseLong = 1'b1;
    i_op.pulse(300 * TICK);
    settle("below long minimum");
    i_op.pulse(400 * TICK);
    expPend = 1'b0;
    settle("valid long pulse");
    $display("test rearm done");
    startPermitEn = 1'b1;
    startStop = 1'b1;
    settle("start permit low");
    startStop = 1'b0;
    step(2);
    startPermit = 1'b1;
    startStop = 1'b1;
    expPermit = 1'b1;
    settle("start");
    startPermit = 1'b0;
    settle("start permit ignored");
    startStop = 1'b0;
    startPermitEn = 1'b0;
    {expPermit, expPend} = 2'b01;
    settle("stop arms lock");
    mainPermit = 1'b0;
    expPend = 1'b0;
    settle("pending gated");
    mainPermit = 1'b1;
    expPend = 1'b1;
    settle("pending shown");
    minPulseLong = 1'b0;
    i_op.pulse(30100 * TICK);
    settle("overlong pulse");
    i_op.pulse(120 * TICK);
    expPend = 1'b0;
    settle("valid short pulse");
    $display("test lock done");
    lockMode = psp_pkg::LOCK_NONE;
    startStop = 1'b1;
    expPermit = 1'b1;
    settle("mode none start");
    mainPermit = 1'b0;
    expPermit = 1'b0;
    settle("main drop");
    {startStop, mainPermit, singleCycleEn} = 3'b011;
    step(2);
    startStop = 1'b1;
    expPermit = 1'b1;
    settle("restart");
    tdc = 1'b1;
    expPermit = 1'b0;
    settle("top rise");
    $display("test single cycle done");
    lockMode = psp_pkg::LOCK_TDC;
    {startStop, tdc} = 2'b00;
    step(2);
    startStop = 1'b1;
    expPermit = 1'b1;
    settle("mode top start");
    startStop = 1'b0;
    expPermit = 1'b0;
    settle("mode top ignores stop");
    startStop = 1'b1;
    expPermit = 1'b1;
    settle("mode top restart");
    tdc = 1'b1;
    {expPermit, expPend} = 2'b01;
    settle("mode top locks");
    i_op.pulse(120 * TICK);
    lockMode = psp_pkg::LOCK_STARTSTOP;
    {startStop, tdc, expPend} = 3'b000;
    step(2);
    startStop = 1'b1;
    expPermit = 1'b1;
    settle("mode start start");
    mainPermit = 1'b0;
    expPermit = 1'b0;
    settle("mode start main drop");
    mainPermit = 1'b1;
    expPend = 1'b1;
    settle("mode start locked");
    $display("test modes done");
    for (int i = 0; i < 16; i++) begin
      step(1);
      lfsrQ = lfsr_next(lfsrQ);
      mainPermit = lfsrQ[0];
      startPermit = lfsrQ[1];
      #1 check("inverted main", mainPermitInv, ~mainPermit);
    end
    $display("test inverted done");
    summarize();
  end
endmodule
